// *** sinc3_decimator_output_coder.sv ***
// Sinc-cubed decimators for six channels, output coder, sample FIFO, APB registers.
// Assumes pclk is the pin master clock and the modulator bits arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO, flip-flop storage, valid/ready on both sides
module sample_fifo #(
	parameter int unsigned WIDTH = 19,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];   // Storage
	logic [AW-1:0]    wr_ptr;        // Write index
	logic [AW-1:0]    rd_ptr;        // Read index
	logic             push;
	logic             pop;

	assign in_ready  = (level != DEPTH[AW:0]);  // Honest full
	assign out_valid = (level != '0);          // Honest empty
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage write, no reset needed on data
	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				level <= level + 1'b1;
			end else if (pop && !push) begin
				level <= level - 1'b1;
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top: decimators, coder, buffer and register slave
module sinc3_decimator_output_coder (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [5:0]  mod_bits,
	output logic [17:0]      gain_code,
	output logic             ref_high_level_select,
	output logic             ref_output_enable,
	output logic             mixed_mode,
	output logic             sample_tick
);
	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0]  port_mode_reg;        // Port mode bits
	logic [7:0]  clk_ctrl;             // Master divider code
	logic [7:0]  ref_ctrl;             // Reference control bits
	logic [7:0]  gain_reg [3];         // Gain registers D, E, F
	logic        overrun;              // Sticky: sample dropped
	logic [5:0]  mod_meta;             // First synchroniser stage
	logic [5:0]  mod_sync;             // Second stage, safe to read
	logic [2:0]  div_cnt;              // Master divider count
	logic [2:0]  div_max;              // Terminal count from code
	logic        device_master_clock_en;             // Device master clock enable
	logic [2:0]  mod_cnt;              // Device clocks per modulator bit
	logic        mod_en;               // Modulator bit strobe
	logic [4:0]  dec_cnt;              // Bits per decimated word
	logic        dec_en;               // Decimated word strobe
	logic [15:0] word [sinc3_pkg::N_CHAN];   // Coded word per channel
	logic [15:0] hold [sinc3_pkg::N_CHAN];   // Held until buffered
	logic [5:0]  pend;                 // Channel holds an unbuffered word
	logic [2:0]  pick;                 // Lowest pending channel
	logic        pick_ok;              // Some channel pending
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic        fifo_pop;
	sinc3_pkg::sample_t fifo_in;
	sinc3_pkg::sample_t fifo_out;
	logic [5:0]  fifo_level;
	logic        setup_done;           // Access phase awaiting answer
	logic        complete;             // Access completes at this edge
	logic [31:0] next_prdata;
	logic        next_slverr;

	////////////////////////////////////////////////////////////////////////////
	// Modulator bit synchroniser; first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mod_meta <= '0;
			mod_sync <= '0;
		end else begin
			mod_meta <= mod_bits;
			mod_sync <= mod_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Master clock divider, codes 0..4 give /1../5, others /1
	always_comb begin
		case (clk_ctrl[sinc3_pkg::POS_DIV_FIELD +: 3])
			3'h1:    div_max = 3'h1;
			3'h2:    div_max = 3'h2;
			3'h3:    div_max = 3'h3;
			3'h4:    div_max = 3'h4;
			default: div_max = 3'h0;
		endcase
	end

	// Device clock enable from pin clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt  <= '0;
			device_master_clock_en <= 1'b0;
		end else if (div_cnt >= div_max) begin
			div_cnt  <= '0;
			device_master_clock_en <= 1'b1;
		end else begin
			div_cnt  <= div_cnt + 1'b1;
			device_master_clock_en <= 1'b0;
		end
	end

	// One modulator bit every eight device clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mod_cnt <= '0;
			mod_en  <= 1'b0;
		end else begin
			mod_en <= 1'b0;
			if (device_master_clock_en) begin
				mod_cnt <= mod_cnt + 1'b1;
				mod_en  <= (mod_cnt == 3'(sinc3_pkg::MOD_DIV - 1));
			end
		end
	end

	// Word strobe once per 32 modulator bits, i.e. device clock/256
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_cnt <= '0;
		end else if (mod_en) begin
			dec_cnt <= dec_cnt + 1'b1;
		end
	end
	assign dec_en = mod_en && (dec_cnt == 5'(sinc3_pkg::DEC_RATE - 1));

	////////////////////////////////////////////////////////////////////////////
	// Per-channel sinc-cubed filter and coder
	for (genvar ch = 0; ch < sinc3_pkg::N_CHAN; ch++) begin : g_chan
		logic signed [sinc3_pkg::ACC_W-1:0] in_val;     // +1 or -1
		logic signed [sinc3_pkg::ACC_W-1:0] int1, int2, int3;
		logic signed [sinc3_pkg::ACC_W-1:0] dly1, dly2, dly3;
		logic signed [sinc3_pkg::ACC_W-1:0] cmb1, cmb2, cmb3;
		logic signed [sinc3_pkg::ACC_W-2:0] half;       // Accumulator over two
		logic signed [14:0] res15;                      // Clipped result
		logic               at_full;

		assign in_val = mod_sync[ch] ? (sinc3_pkg::ACC_W)'(1) : '1;

		// Integrators wrap freely; 18 bits hold the full 32768 swing
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				int1 <= '0;
				int2 <= '0;
				int3 <= '0;
			end else if (mod_en) begin
				int1 <= int1 + in_val;
				int2 <= int2 + int1;
				int3 <= int3 + int2;
			end
		end

		// Combs at output rate: delay 1 there is delay 32 at the input
		assign cmb1 = int3 - dly1;
		assign cmb2 = cmb1 - dly2;
		assign cmb3 = cmb2 - dly3;

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				dly1 <= '0;
				dly2 <= '0;
				dly3 <= '0;
			end else if (dec_en) begin
				dly1 <= int3;
				dly2 <= cmb1;
				dly3 <= cmb2;
			end
		end

		// Scale by half and clip the top code
		assign half    = cmb3[sinc3_pkg::ACC_W-1:1];
		assign at_full = (half >= 17'(sinc3_pkg::POS_FULL));
		assign res15   = at_full ? sinc3_pkg::POS_FULL : half[14:0];

		// Mixed mode keeps 15 bits, flag 0 marks data
		always_comb begin
			if (port_mode_reg[sinc3_pkg::BIT_DATA_MODE]
			    && port_mode_reg[sinc3_pkg::BIT_MIXED_MODE]) begin
				word[ch] = {1'b0, res15};
			end else if (at_full) begin
				word[ch] = sinc3_pkg::WORD_SAT;
			end else begin
				word[ch] = {res15, 1'b0};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Lowest pending channel goes to the buffer first
	always_comb begin
		pick    = '0;
		pick_ok = 1'b0;
		for (int i = sinc3_pkg::N_CHAN - 1; i >= 0; i--) begin
			if (pend[i]) begin
				pick    = 3'(i);
				pick_ok = 1'b1;
			end
		end
	end

	// Hold registers: new words land here; an unbuffered one is overwritten
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend <= '0;
			for (int i = 0; i < sinc3_pkg::N_CHAN; i++) begin
				hold[i] <= '0;
			end
		end else if (dec_en) begin
			pend <= '1;
			for (int i = 0; i < sinc3_pkg::N_CHAN; i++) begin
				hold[i] <= word[i];
			end
		end else if (pick_ok && fifo_in_ready) begin
			pend[pick] <= 1'b0;
		end
	end

	assign fifo_in.chan = pick;
	assign fifo_in.word = hold[pick];

	// Buffer stalls the hold drain when full, so back-pressure is real
	sample_fifo #(
		.WIDTH (sinc3_pkg::SAMPLE_W),
		.DEPTH (sinc3_pkg::FIFO_DEP)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (pick_ok && !dec_en),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out),
		.level     (fifo_level)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB timing: one wait state, answer registered
	assign setup_done = psel && penable && !pready;
	assign complete   = psel && penable && pready;
	// Pop on the edge that registers the read answer, so a word that lands
	// during the wait state is never popped unreported
	assign fifo_pop   = setup_done && !pwrite && (paddr == sinc3_pkg::OFS_SAMPLE);

	// Read mux, unmapped reads give zero and an error
	always_comb begin
		next_prdata = '0;
		next_slverr = 1'b0;
		case (paddr)
			sinc3_pkg::OFS_PORT_MODE: next_prdata = {24'h0, port_mode_reg};
			sinc3_pkg::OFS_CLK_CTRL:  next_prdata = {24'h0, clk_ctrl};
			sinc3_pkg::OFS_REF_CTRL:  next_prdata = {24'h0, ref_ctrl};
			sinc3_pkg::OFS_GAIN_D:    next_prdata = {24'h0, gain_reg[0]};
			sinc3_pkg::OFS_GAIN_E:    next_prdata = {24'h0, gain_reg[1]};
			sinc3_pkg::OFS_GAIN_F:    next_prdata = {24'h0, gain_reg[2]};
			sinc3_pkg::OFS_STATUS:    next_prdata = {23'h0, overrun, 2'h0, fifo_level};
			sinc3_pkg::OFS_SAMPLE:    next_prdata = {12'h0, fifo_out_valid, fifo_out};
			default:                  next_slverr = 1'b1;
		endcase
	end

	// Answer flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_done;
			pslverr <= setup_done && next_slverr;
			if (setup_done && !pwrite) begin
				prdata <= next_prdata;
			end
		end
	end

	// Register writes, all cleared by reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_mode_reg <= sinc3_pkg::CTRL_RESET;
			clk_ctrl      <= sinc3_pkg::CTRL_RESET;
			ref_ctrl      <= sinc3_pkg::CTRL_RESET;
			for (int i = 0; i < 3; i++) begin
				gain_reg[i] <= sinc3_pkg::CTRL_RESET;
			end
		end else if (complete && pwrite) begin
			case (paddr)
				sinc3_pkg::OFS_PORT_MODE: port_mode_reg <= pwdata[7:0];
				sinc3_pkg::OFS_CLK_CTRL:  clk_ctrl      <= pwdata[7:0];
				sinc3_pkg::OFS_REF_CTRL:  ref_ctrl      <= pwdata[7:0];
				sinc3_pkg::OFS_GAIN_D:    gain_reg[0]   <= pwdata[7:0];
				sinc3_pkg::OFS_GAIN_E:    gain_reg[1]   <= pwdata[7:0];
				sinc3_pkg::OFS_GAIN_F:    gain_reg[2]   <= pwdata[7:0];
				default:                  ;
			endcase
		end
	end

	// Overrun: set when a word is replaced unbuffered; set beats clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overrun <= 1'b0;
		end else if (dec_en && (pend != '0)) begin
			overrun <= 1'b1;
		end else if (complete && pwrite && (paddr == sinc3_pkg::OFS_STATUS)
		             && pwdata[sinc3_pkg::BIT_OVERRUN]) begin
			overrun <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Decoded control outputs, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_code             <= '0;
			ref_high_level_select <= 1'b0;
			ref_output_enable     <= 1'b0;
			mixed_mode            <= 1'b0;
			sample_tick           <= 1'b0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				gain_code[6*i +: 3]     <= gain_reg[i][2:0];
				gain_code[6*i + 3 +: 3] <= gain_reg[i][sinc3_pkg::POS_GAIN_HI +: 3];
			end
			ref_high_level_select <= ref_ctrl[sinc3_pkg::BIT_REF_HIGH];
			ref_output_enable     <= ref_ctrl[sinc3_pkg::BIT_REF_OUT_EN];
			mixed_mode            <= port_mode_reg[sinc3_pkg::BIT_DATA_MODE]
			                         && port_mode_reg[sinc3_pkg::BIT_MIXED_MODE];
			sample_tick           <= dec_en;
		end
	end
endmodule

`default_nettype wire

// *** sinc3_pkg.sv ***
// Constants and types shared by the sinc-cubed decimator and its sample path.
// Assumes a single clock domain on pclk and an APB register slave.
//
// Overview of operation
// - Six parallel channels, each with own filter
// - One modulator bit per eight device clocks
// - Decimate by 32 to 15-bit result
// - Three integrators, three combs, delay 32
// - Sample words use two's complement
// - Data mode: shift left, LSB zero
// - Data mode: at or above full scale output 7fff
// - Mixed mode: 15 bits, MSB flags data
// - Three-bit gain code in registers D-F
// - Register C bit 7 selects high reference
// - Register C bit 6 enables reference output
// - Output sample updates at sample rate
// - Device clock from programmable master divider
// - Register bit 7 is MSB, 0 LSB
// - Mixed mode when mode bits 0,1 set
// - Reset clears registers and filter state
package sinc3_pkg;
	////////////////////////////////////////////////////////////////////////////
	// Dimensions
	localparam int unsigned N_CHAN   = 6;   // Converter channels
	localparam int unsigned ACC_W    = 18;  // Integrator width, holds +/-32768
	localparam int unsigned FIFO_DEP = 32;  // Sample buffer depth
	localparam int unsigned MOD_DIV  = 8;   // Device clocks per modulator bit
	localparam int unsigned DEC_RATE = 32;  // Modulator bits per output word

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets on APB
	localparam logic [7:0] OFS_PORT_MODE = 8'h00; // Port mode, bits 0 and 1
	localparam logic [7:0] OFS_CLK_CTRL  = 8'h04; // Master divider in bits 6:4
	localparam logic [7:0] OFS_REF_CTRL  = 8'h08; // Reference control
	localparam logic [7:0] OFS_GAIN_D    = 8'h0c; // Gains of channels 0 and 1
	localparam logic [7:0] OFS_GAIN_E    = 8'h10; // Gains of channels 2 and 3
	localparam logic [7:0] OFS_GAIN_F    = 8'h14; // Gains of channels 4 and 5
	localparam logic [7:0] OFS_STATUS    = 8'h18; // Fill level and overrun
	localparam logic [7:0] OFS_SAMPLE    = 8'h1c; // Pops one sample word

	////////////////////////////////////////////////////////////////////////////
	// Field positions and reset values
	localparam int unsigned BIT_DATA_MODE  = 0;
	localparam int unsigned BIT_MIXED_MODE = 1;
	localparam int unsigned BIT_REF_HIGH   = 7;
	localparam int unsigned BIT_REF_OUT_EN = 6;
	localparam int unsigned POS_DIV_FIELD  = 4;
	localparam int unsigned POS_GAIN_HI    = 4;  // Odd channel gain position
	localparam int unsigned BIT_OVERRUN    = 8;  // Status overrun, write 1 clears
	localparam logic [7:0]  CTRL_RESET     = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Output coding
	localparam logic signed [14:0] POS_FULL = 15'sh3fff;
	localparam logic signed [15:0] WORD_SAT = 16'sh7fff;

	// One buffered sample: channel number and coded word
	typedef struct packed {
		logic [2:0]  chan;
		logic [15:0] word;
	} sample_t;
	localparam int unsigned SAMPLE_W = $bits(sample_t);
endpackage

// *** sinc3_monitor.sv ***
// Checker for the decimator top: APB answer timing, control outputs, tick pacing.
// Sees the top ports only; attached by the bind after the module.
`timescale 1ns/1ps
`default_nettype none
module sinc3_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [5:0]  mod_bits,
	input wire logic [17:0] gain_code,
	input wire logic        ref_high_level_select,
	input wire logic        ref_output_enable,
	input wire logic        mixed_mode,
	input wire logic        sample_tick
);
	////////////////////////////////////////
	// Single domain: clock and reset given once
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Cycles since last tick; saturates so slow dividers cannot wrap it
	logic [10:0] gap;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			gap <= 11'h7ff;
		else if (sample_tick)
			gap <= 11'h000;
		else if (gap != 11'h7ff)
			gap <= gap + 11'h001;
	end

	////////////////////////////////////////
	// Transfer steps
	sequence setup_phase;
		psel && !penable;
	endsequence
	sequence wr_done(logic [7:0] a);
		psel && penable && pready && pwrite && paddr == a;
	endsequence
	// Outputs are registered from the control register, one edge after completion
	property ref_write;
		logic [7:0] v;
		(wr_done(sinc3_pkg::OFS_REF_CTRL), v = pwdata[7:0]) |=> ##1
			ref_high_level_select == v[7] && ref_output_enable == v[6];
	endproperty
	property gain_write;
		logic [7:0] v;
		(wr_done(sinc3_pkg::OFS_GAIN_D), v = pwdata[7:0]) |=> ##1
			gain_code[5:0] == {v[6:4], v[2:0]};
	endproperty
	property mode_write;
		logic [7:0] v;
		(wr_done(sinc3_pkg::OFS_PORT_MODE), v = pwdata[7:0]) |=> ##1
			mixed_mode == (v[0] && v[1]);
	endproperty

	AST_PREADY_WAIT: assert property (setup_phase |=> !pready ##1 pready)
		else $error("answer not one wait state after setup");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	AST_ERR_MAP: assert property (pready |-> pslverr == (paddr > 8'h1c || paddr[1:0] != 2'h0))
		else $error("error response does not match address map");
	AST_REF_BITS: assert property (ref_write)
		else $error("reference outputs differ from written bits");
	AST_GAIN_D: assert property (gain_write)
		else $error("gain code differs from written field");
	AST_MIXED: assert property (mode_write)
		else $error("mixed mode differs from both mode bits");
	AST_TICK_PULSE: assert property (sample_tick |=> !sample_tick)
		else $error("sample tick longer than one cycle");
	AST_TICK_GAP: assert property (sample_tick |-> gap >= 11'h0ff)
		else $error("words closer than 256 clocks");
	AST_RESET_CLEAR: assert property ($rose(presetn) |-> !pready && !sample_tick &&
		gain_code == 18'h0 && !mixed_mode && !ref_high_level_select && !ref_output_enable)
		else $error("outputs not cleared by reset");
endmodule

bind sinc3_decimator_output_coder sinc3_monitor sinc3_monitor_inst (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mod_bits, .gain_code,
	.ref_high_level_select, .ref_output_enable, .mixed_mode, .sample_tick);
`default_nettype wire

// *** mod_source.sv ***
// Modulator bit source for six channels: steady low, steady high or toggling.
// Assumes the device clock equals pclk, so toggles land once per modulator sample.
`timescale 1ns/1ps
`default_nettype none
module mod_source (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] pattern,
	output logic      [5:0]  mod_bits
);
	logic [2:0] phase; // Position within one modulator period
	logic       flip;  // Toggling level, mean zero over any even run

	// Toggle once every eight clocks, one new bit per modulator sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 3'h0;
			flip <= 1'b0;
		end else begin
			phase <= phase + 3'h1;
			if (phase == 3'h7)
				flip <= !flip;
		end
	end

	// Two bits a channel: 0 low, 1 high, 2 toggling
	always_comb begin
		for (int k = 0; k < 6; k++)
			mod_bits[k] = pattern[2*k+1] ? flip : pattern[2*k];
	end
endmodule
`default_nettype wire

// *** test_sinc3_decimator_output_coder.sv ***
// Self-checking bench for the six-channel decimator with APB access.
// Drives a modulator source model; expects the one-wait-state APB slave.
`timescale 1ns/1ps
`default_nettype none
module test_sinc3_decimator_output_coder;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [11:0] pattern = 12'h000;
	logic [31:0] prdata;
	logic [17:0] gain_code;
	logic [5:0]  mod_bits;
	logic        pready, pslverr, ref_hi, ref_oe, mixed_mode, sample_tick;
	logic [31:0] rd;           // Last read data
	logic        err;          // Last error response
	int          mismatches = 0;
	int          total_checks = 0;
	int          exp_q[$];     // Expected words of one frame

	always #50 pclk = ~pclk;

	sinc3_decimator_output_coder sinc3_decimator_output_coder_inst (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mod_bits, .gain_code,
		.ref_high_level_select(ref_hi), .ref_output_enable(ref_oe), .mixed_mode, .sample_tick);
	mod_source mod_source_inst (.pclk, .presetn, .pattern, .mod_bits);

	////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One APB transfer; request held until ready is seen high, watchdog bounds it
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Wait for a word tick, bounded; returns the edge count
	task automatic wait_tick(output int n);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (sample_tick !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			mismatches++;
			wrap_up();
		end
	endtask

	// Pop until the buffer reports empty
	task automatic flush();
		for (int i = 0; i < 64; i++) begin
			apb(1'b0, sinc3_pkg::OFS_SAMPLE, 32'h0);
			if (rd[19] !== 1'b1)
				break;
		end
	endtask

	// Settled channel: mean level -1, 0, +1 to the coded word
	function automatic int model_word(int lvl, int mixed);
		int r;
		r = lvl * 32768 / 2;
		if (r > 16383)
			return mixed ? 16383 : 32'h7fff;
		return mixed ? (r & 32'h7fff) : ((r * 2) & 32'hffff);
	endfunction

	// Random levels, settle five words, then read one frame
	task automatic convert(input int mixed);
		int lvl[6];
		int n;
		logic [11:0] pat;
		pat = 12'h000;
		for (int k = 0; k < 6; k++) begin
			lvl[k] = $urandom_range(2);
			pat[2*k +: 2] = 2'(lvl[k]);
			exp_q.push_back(model_word(lvl[k] == 2 ? 0 : lvl[k] * 2 - 1, mixed));
		end
		pattern <= pat;
		repeat (5) wait_tick(n);
		repeat (10) @(posedge pclk);
		flush();
		wait_tick(n);
		repeat (10) @(posedge pclk);
		for (int k = 0; k < 6; k++) begin
			apb(1'b0, sinc3_pkg::OFS_SAMPLE, 32'h0);
			check("sample channel", k, rd[18:16]);
			check("sample word", exp_q.pop_front(), rd[15:0]);
		end
	endtask

	// Word spacing for a master divider setting
	task automatic tick_gap(input int div);
		int n;
		apb(1'b1, sinc3_pkg::OFS_CLK_CTRL, 32'(div << 4));
		repeat (3) wait_tick(n);
		check("tick spacing", 256 * (div + 1), n);
	endtask

	////////////////////////////////////////
	initial begin
		int n;
		void'($urandom(32'hc29a));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 6; a++) begin
			apb(1'b0, 8'(a * 4), 32'h0);
			check("reset value", 0, rd);
		end
		apb(1'b1, 8'h20, 32'h0000_00ff);
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped error", 1, err);
		check("unmapped data", 0, rd);
		// Every gain code, opposite codes on odd channels
		for (int g = 0; g < 8; g++) begin
			for (int a = 0; a < 3; a++)
				apb(1'b1, 8'(12 + a * 4), 32'(g | ((7 - g) << 4)));
			apb(1'b0, sinc3_pkg::OFS_GAIN_F, 32'h0);
			check("gain readback", g | ((7 - g) << 4), rd);
			check("gain codes", {3{3'(7 - g), 3'(g)}}, gain_code);
		end
		for (int r = 0; r < 4; r++) begin
			apb(1'b1, sinc3_pkg::OFS_REF_CTRL, 32'(r << 6));
			apb(1'b0, sinc3_pkg::OFS_REF_CTRL, 32'h0);
			check("reference bits", r, {ref_hi, ref_oe});
		end
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, sinc3_pkg::OFS_PORT_MODE, m);
			apb(1'b0, sinc3_pkg::OFS_PORT_MODE, 32'h0);
			check("mixed mode", m == 3, mixed_mode);
		end
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, sinc3_pkg::OFS_PORT_MODE, i[0] ? 32'h3 : 32'h1);
			convert(i % 2);
		end
		// Every divider code that divides, slowest first
		for (int d = 4; d >= 0; d--)
			tick_gap(d);
		// Overfill the buffer with no reads, then drain it dry
		wait_tick(n);
		repeat (10) @(posedge pclk);
		flush();
		repeat (7) wait_tick(n);
		repeat (10) @(posedge pclk);
		apb(1'b0, sinc3_pkg::OFS_STATUS, 32'h0);
		check("buffer level", 32, rd[5:0]);
		check("overrun set", 1, rd[8]);
		apb(1'b1, sinc3_pkg::OFS_STATUS, 32'h100);
		apb(1'b0, sinc3_pkg::OFS_STATUS, 32'h0);
		check("overrun cleared", 0, rd[8]);
		flush();
		check("empty pop", 0, rd[19]);
		// Reset in mid-run clears control state
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, sinc3_pkg::OFS_REF_CTRL, 32'h0);
		check("reference after reset", 0, {rd[7:0], ref_hi, gain_code});
		wrap_up();
	end

	// Hang guard, well past the expected run length
	initial begin
		repeat (40000) @(posedge pclk);
		mismatches++;
		wrap_up();
	end
endmodule
`default_nettype wire
